// ==== src/bdec_decoder.v ====
// boot memory map decoder with configuration window and boot sequencer
`timescale 1ns/10ps
`default_nettype none
`include "bdec_defs.vh"
// How it works
// - after reset, boot rom aliased 16x4K from 0, program flash at 0x0001_0000
// - before jumping to flash, map becomes flash at 0, rom at 0x0001_0000
// - data flash 0x0001_8800 and data ram 0x0001_9000 in both maps
// - thirteen 256-byte peripheral windows, one per 64K from 0x0002_0000 to 0x000E_0000
// - every reset starts in rom init before any flash checksum
// - check first 2 kB of flash first; valid means jump to flash 0
// - if short check fails, check all 32 kB; valid means jump
// - both checks bad: stay in rom serving host commands until told to execute
// - flash, rom and ram selects have configurable base and 1 kB to 16 MB size
// - power-on reset restores the default boot map
// - any access to decoder registers stalls the processor one wait state
// - configuration writes only take effect in privileged mode
module bdec_decoder (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire bus_req,
    input wire bus_wr,
    input wire bus_priv,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    output wire bus_wait,
    output reg [31:0] bus_rdata_ff,
    output wire pfl_sel,
    output wire rom_sel,
    output wire dfl_sel,
    output wire ram_sel,
    output wire [`BDEC_PER_NUM-1:0] per_sel,
    output wire [23:0] mem_offset,
    input wire init_done,
    input wire chk_done,
    input wire chk_ok,
    input wire host_exec,
    output reg chk_start_ff,
    output reg [5:0] chk_len_kb_ff,
    output reg boot_jump_ff,
    output wire host_cmd_mode
);
    // ==========================================
    // boot states
    localparam [2:0] ST_INIT = 3'h0;
    localparam [2:0] ST_CHK_SHORT = 3'h1;
    localparam [2:0] ST_CHK_FULL = 3'h2;
    localparam [2:0] ST_HOST = 3'h3;
    localparam [2:0] ST_JUMP = 3'h4;
    localparam [2:0] ST_RUN = 3'h5;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg wait_ff;
    reg normal_ff;
    reg [31:0] pfl_base_ff;
    reg [3:0] pfl_size_ff;
    reg [31:0] rom_base_ff;
    reg [3:0] rom_size_ff;
    reg [31:0] dfl_base_ff;
    reg [3:0] dfl_size_ff;
    reg [31:0] ram_base_ff;
    reg [3:0] ram_size_ff;
    reg [31:0] nxt_rdata;

    // ==========================================
    // window decode
    wire pfl_hit;
    wire rom_hit;
    wire dfl_hit;
    wire ram_hit;
    wire [23:0] pfl_off;
    wire [23:0] rom_off;
    wire [23:0] dfl_off;
    wire [23:0] ram_off;
    wire cfg_hit;
    wire [5:0] reg_idx;
    wire per_zone;
    wire cfg_wr;
    wire apply_normal;

    function [31:0] kb_align;
        input [31:0] value;
        begin
            kb_align = {value[31:10], 10'h000};
        end
    endfunction

    bdec_region u_pfl (.addr(bus_addr), .base(pfl_base_ff), .size_code(pfl_size_ff),
        .hit(pfl_hit), .offset(pfl_off));
    bdec_region u_rom (.addr(bus_addr), .base(rom_base_ff), .size_code(rom_size_ff),
        .hit(rom_hit), .offset(rom_off));
    bdec_region u_dfl (.addr(bus_addr), .base(dfl_base_ff), .size_code(dfl_size_ff),
        .hit(dfl_hit), .offset(dfl_off));
    bdec_region u_ram (.addr(bus_addr), .base(ram_base_ff), .size_code(ram_size_ff),
        .hit(ram_hit), .offset(ram_off));

    assign cfg_hit = bus_req && (bus_addr[31:8] == `BDEC_CFG_BASE);
    assign reg_idx = bus_addr[7:2];
    // overlapping windows resolve flash, rom, data flash, ram so selects stay one-hot
    assign pfl_sel = bus_req && pfl_hit;
    assign rom_sel = bus_req && rom_hit && !pfl_hit;
    assign dfl_sel = bus_req && dfl_hit && !pfl_hit && !rom_hit;
    assign ram_sel = bus_req && ram_hit && !pfl_hit && !rom_hit && !dfl_hit;
    // rom is 4K deep, so a larger window simply aliases it
    assign mem_offset = pfl_sel ? pfl_off :
                        rom_sel ? {12'h000, rom_off[`BDEC_ROM_AW-1:0]} :
                        dfl_sel ? dfl_off :
                        ram_sel ? ram_off : 24'h00_0000;

    assign per_zone = bus_req && (bus_addr[31:20] == 12'h000) && (bus_addr[15:8] == 8'h00);
    genvar gi;
    generate
        for (gi = 0; gi < `BDEC_PER_NUM; gi = gi + 1)
        begin : g_per
            // 256-byte window at 0x000N_0000
            assign per_sel[gi] = per_zone && (bus_addr[19:16] == (`BDEC_PER_FIRST + gi));
        end
    endgenerate

    // first cycle of a register access is a wait state
    assign bus_wait = cfg_hit && !wait_ff;
    // user-mode writes are dropped
    assign cfg_wr = cfg_hit && wait_ff && bus_wr && bus_priv;
    assign apply_normal = (state_ff == ST_JUMP) ||
                          (cfg_wr && (reg_idx == `BDEC_REG_CTRL) && bus_wdata[0]);
    assign host_cmd_mode = (state_ff == ST_HOST);

    // ==========================================
    // boot sequencer
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_INIT: if (init_done) nxt_state = ST_CHK_SHORT;
            ST_CHK_SHORT:
            begin
                if (chk_done)
                    nxt_state = chk_ok ? ST_JUMP : ST_CHK_FULL;
            end
            ST_CHK_FULL:
            begin
                if (chk_done)
                    nxt_state = chk_ok ? ST_JUMP : ST_HOST;
            end
            ST_HOST: if (host_exec) nxt_state = ST_JUMP;
            ST_JUMP: nxt_state = ST_RUN;
            ST_RUN: nxt_state = ST_RUN;
            default: nxt_state = ST_INIT;
        endcase
    end

    always @*
    begin
        nxt_rdata = 32'h0000_0000; // unmapped and write cycles read zero
        if (cfg_hit && !wait_ff && !bus_wr)
        begin
            case (reg_idx)
                `BDEC_REG_CTRL: nxt_rdata = {31'h0000_0000, normal_ff};
                `BDEC_REG_PFL_BASE: nxt_rdata = pfl_base_ff;
                `BDEC_REG_PFL_SIZE: nxt_rdata = {28'h000_0000, pfl_size_ff};
                `BDEC_REG_ROM_BASE: nxt_rdata = rom_base_ff;
                `BDEC_REG_ROM_SIZE: nxt_rdata = {28'h000_0000, rom_size_ff};
                `BDEC_REG_DFL_BASE: nxt_rdata = dfl_base_ff;
                `BDEC_REG_DFL_SIZE: nxt_rdata = {28'h000_0000, dfl_size_ff};
                `BDEC_REG_RAM_BASE: nxt_rdata = ram_base_ff;
                `BDEC_REG_RAM_SIZE: nxt_rdata = {28'h000_0000, ram_size_ff};
                `BDEC_REG_BOOT: nxt_rdata = {29'h0000_0000, state_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // state
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_INIT;
            wait_ff <= 1'b0;
            normal_ff <= 1'b0;
            pfl_base_ff <= `BDEC_RST_PFL_BASE;
            pfl_size_ff <= `BDEC_RST_PFL_SIZE;
            rom_base_ff <= `BDEC_RST_ROM_BASE;
            rom_size_ff <= `BDEC_RST_ROM_SIZE;
            dfl_base_ff <= `BDEC_DFL_BASE;
            dfl_size_ff <= `BDEC_DFL_SIZE;
            ram_base_ff <= `BDEC_RAM_BASE;
            ram_size_ff <= `BDEC_RAM_SIZE;
            bus_rdata_ff <= 32'h0000_0000;
            chk_start_ff <= 1'b0;
            chk_len_kb_ff <= 6'h00;
            boot_jump_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            wait_ff <= bus_wait;
            bus_rdata_ff <= nxt_rdata;
            chk_start_ff <= (state_ff == ST_INIT && nxt_state == ST_CHK_SHORT) ||
                            (state_ff == ST_CHK_SHORT && nxt_state == ST_CHK_FULL);
            if (nxt_state == ST_CHK_SHORT)
                chk_len_kb_ff <= `BDEC_CHK_SHORT_KB;
            else if (nxt_state == ST_CHK_FULL)
                chk_len_kb_ff <= `BDEC_CHK_FULL_KB;
            boot_jump_ff <= (state_ff == ST_JUMP);
            if (apply_normal)
            begin
                // normal map just before control passes to flash
                normal_ff <= 1'b1;
                pfl_base_ff <= `BDEC_NRM_PFL_BASE;
                pfl_size_ff <= `BDEC_NRM_PFL_SIZE;
                rom_base_ff <= `BDEC_NRM_ROM_BASE;
                rom_size_ff <= `BDEC_NRM_ROM_SIZE;
            end
            else if (cfg_wr)
            begin
                case (reg_idx)
                    `BDEC_REG_PFL_BASE: pfl_base_ff <= kb_align(bus_wdata);
                    `BDEC_REG_PFL_SIZE: pfl_size_ff <= bus_wdata[3:0];
                    `BDEC_REG_ROM_BASE: rom_base_ff <= kb_align(bus_wdata);
                    `BDEC_REG_ROM_SIZE: rom_size_ff <= bus_wdata[3:0];
                    `BDEC_REG_DFL_BASE: dfl_base_ff <= kb_align(bus_wdata);
                    `BDEC_REG_DFL_SIZE: dfl_size_ff <= bus_wdata[3:0];
                    `BDEC_REG_RAM_BASE: ram_base_ff <= kb_align(bus_wdata);
                    `BDEC_REG_RAM_SIZE: ram_size_ff <= bus_wdata[3:0];
                    default: normal_ff <= normal_ff;
                endcase
            end
        end
    end
endmodule // bdec_decoder
`default_nettype wire

// ==== src/bdec_defs.vh ====
// constants for the boot memory map decoder
`ifndef BDEC_DEFS_VH
`define BDEC_DEFS_VH
// ==========================================
// reset map
`define BDEC_RST_ROM_BASE 32'h0000_0000
`define BDEC_RST_ROM_SIZE 4'h6
`define BDEC_RST_PFL_BASE 32'h0001_0000
`define BDEC_RST_PFL_SIZE 4'h5
// ==========================================
// normal map
`define BDEC_NRM_PFL_BASE 32'h0000_0000
`define BDEC_NRM_PFL_SIZE 4'h5
`define BDEC_NRM_ROM_BASE 32'h0001_0000
`define BDEC_NRM_ROM_SIZE 4'h2
// ==========================================
// fixed in both maps
`define BDEC_DFL_BASE 32'h0001_8800
`define BDEC_DFL_SIZE 4'h1
`define BDEC_RAM_BASE 32'h0001_9000
`define BDEC_RAM_SIZE 4'h2
// ==========================================
// size code: region is (1 kB << code), code 0 .. 14
`define BDEC_SIZE_MAX 4'he
`define BDEC_KB_SHIFT 5'h0a
`define BDEC_ROM_AW 12
// ==========================================
// peripheral windows, one per 64K step
`define BDEC_PER_FIRST 4'h2
`define BDEC_PER_LAST 4'he
`define BDEC_PER_NUM 13
// ==========================================
// decoder configuration window and word index
`define BDEC_CFG_BASE 24'hffff_fe
`define BDEC_REG_CTRL 6'h00
`define BDEC_REG_PFL_BASE 6'h01
`define BDEC_REG_PFL_SIZE 6'h02
`define BDEC_REG_ROM_BASE 6'h03
`define BDEC_REG_ROM_SIZE 6'h04
`define BDEC_REG_DFL_BASE 6'h05
`define BDEC_REG_DFL_SIZE 6'h06
`define BDEC_REG_RAM_BASE 6'h07
`define BDEC_REG_RAM_SIZE 6'h08
`define BDEC_REG_BOOT 6'h09
// ==========================================
// checksum spans in kB
`define BDEC_CHK_SHORT_KB 6'h02
`define BDEC_CHK_FULL_KB 6'h20
`endif

// ==== src/bdec_region.v ====
// one configurable memory select window
`timescale 1ns/10ps
`default_nettype none
`include "bdec_defs.vh"
module bdec_region (
    input wire [31:0] addr,
    input wire [31:0] base,
    input wire [3:0] size_code,
    output wire hit,
    output wire [23:0] offset
);
    // ==========================================
    // match
    wire [3:0] code;
    wire [4:0] shift;
    wire [31:0] span;
    assign code = (size_code > `BDEC_SIZE_MAX) ? `BDEC_SIZE_MAX : size_code;
    assign shift = {1'b0, code} + `BDEC_KB_SHIFT;
    assign span = (32'h0000_0001 << shift) - 32'h0000_0001;
    // region of 1 kB up to 16 MB at a configurable base
    assign hit = ((addr & ~span) == (base & ~span));
    assign offset = addr[23:0] & span[23:0];
endmodule // bdec_region
`default_nettype wire

// ==== testbench/bdec_asserts.sv ====
// port assertions for the boot memory map decoder
`timescale 1ns/10ps
`default_nettype none
module bdec_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic bus_req,
    input wire logic bus_wr,
    input wire logic [31:0] bus_addr,
    input wire logic bus_wait,
    input wire logic [31:0] bus_rdata_ff,
    input wire logic pfl_sel,
    input wire logic rom_sel,
    input wire logic dfl_sel,
    input wire logic ram_sel,
    input wire logic [12:0] per_sel,
    input wire logic [23:0] mem_offset,
    input wire logic init_done,
    input wire logic chk_done,
    input wire logic chk_ok,
    input wire logic host_exec,
    input wire logic chk_start_ff,
    input wire logic [5:0] chk_len_kb_ff,
    input wire logic boot_jump_ff
);
    // ==========================================
    // helpers
    default clocking @(posedge clk); endclocking
    // a frozen decoder holds its wait state, so nothing is judged while ce is low
    default disable iff (rst || !ce);
    wire any_sel = pfl_sel | rom_sel | dfl_sel | ram_sel | (|per_sel);
    wire cfg = bus_req && bus_addr[31:8] == 24'hffff_fe;
    wire rd_c0 = cfg && bus_wait && !bus_wr;
    wire good = chk_done & chk_ok;
    wire bad = chk_done & ~chk_ok;
    // ==========================================
    // checks
    chk_wait_cause: assert property (bus_wait |-> cfg)
        else $error("wait outside config access");
    chk_wait_once: assert property ($rose(cfg) |-> bus_wait ##1 !bus_wait)
        else $error("wait not exactly one cycle");
    chk_rdata_idle: assert property (bus_rdata_ff != 32'h0 |-> $past(rd_c0))
        else $error("read data outside read");
    chk_gap_quiet: assert property (bus_addr[31:12] == 20'h0001a || bus_addr[31:11] == 21'h30
        |-> !any_sel) else $error("select in unmapped gap");
    chk_dfl_ram: assert property (bus_req && bus_addr[31:11] == 21'h31 |-> dfl_sel
        && !ram_sel) else $error("data flash select");
    chk_per_win: assert property (bus_req && bus_addr[31:20] == 0 && bus_addr[15:8] == 0
        && bus_addr[19:16] >= 2 && bus_addr[19:16] <= 14
        |-> per_sel == 13'h1 << (bus_addr[19:16] - 4'h2)) else $error("peripheral window");
    chk_rom_fold: assert property (rom_sel && bus_addr[31:16] == 0
        |-> mem_offset == {12'h0, bus_addr[11:0]}) else $error("rom alias offset");
    chk_start_why: assert property (chk_start_ff |-> $past(init_done) && chk_len_kb_ff == 6'h02
        || $past(bad) && chk_len_kb_ff == 6'h20) else $error("bad checksum start");
    chk_jump_why: assert property (boot_jump_ff |-> $past(good, 2) || $past(host_exec, 2))
        else $error("jump without cause");
endmodule // bdec_asserts
bind bdec_decoder bdec_asserts u_chk (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wait(bus_wait), .bus_rdata_ff(bus_rdata_ff),
    .pfl_sel(pfl_sel), .rom_sel(rom_sel), .dfl_sel(dfl_sel), .ram_sel(ram_sel),
    .per_sel(per_sel), .mem_offset(mem_offset), .init_done(init_done), .chk_done(chk_done),
    .chk_ok(chk_ok), .host_exec(host_exec), .chk_start_ff(chk_start_ff),
    .chk_len_kb_ff(chk_len_kb_ff), .boot_jump_ff(boot_jump_ff));
`default_nettype wire

// ==== testbench/bdec_boot_agent.sv ====
// boot firmware and checksum engine model on the decoder boot link
`timescale 1ns/10ps
`default_nettype none
module bdec_boot_agent (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic ok_s,
    input wire logic ok_f,
    input wire logic chk_start_ff,
    input wire logic [5:0] chk_len_kb_ff,
    output logic init_done,
    output logic chk_done,
    output logic chk_ok
);
    int seed = 32'hf0e8;
    int cnt;
    // answer 2..9 cycles after chk_start_ff, so prompt and slow checksums both occur
    always @(posedge clk or posedge rst)
    begin
        cnt <= rst ? 0 : chk_start_ff ? 1 + ($random(seed) & 7) : cnt > 0 ? cnt - 1 : 0;
        init_done <= go & ~rst;
        chk_done <= !rst && cnt == 1;
        // result means nothing outside chk_done, so it churns there
        chk_ok <= cnt == 1 ? (chk_len_kb_ff == 6'h02 ? ok_s : ok_f) : $random(seed);
    end
endmodule // bdec_boot_agent
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the boot memory map decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rst, ce, bus_req, bus_wr, bus_priv, go, ok_s, ok_f, host_exec;
    logic [31:0] bus_addr, bus_wdata, rd;
    wire bus_wait, pfl_sel, rom_sel, dfl_sel, ram_sel, init_done, chk_done, chk_ok;
    wire chk_start_ff, boot_jump_ff, host_cmd_mode;
    wire [12:0] per_sel;
    wire [23:0] mem_offset;
    wire [31:0] bus_rdata_ff;
    wire [5:0] chk_len_kb_ff;
    int i, seed, num_errors, n_tests;
    logic [31:0] corner [12] = '{0, 32'hf004, 32'h10000, 32'h17ffc, 32'h18000, 32'h18800,
        32'h18ffc, 32'h19000, 32'h19ffc, 32'h1a000, 32'h200fc, 32'he0100};
    bdec_decoder u_dut (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .bus_wr(bus_wr),
        .bus_priv(bus_priv), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wait(bus_wait),
        .bus_rdata_ff(bus_rdata_ff), .pfl_sel(pfl_sel), .rom_sel(rom_sel), .dfl_sel(dfl_sel),
        .ram_sel(ram_sel), .per_sel(per_sel), .mem_offset(mem_offset), .init_done(init_done),
        .chk_done(chk_done), .chk_ok(chk_ok), .host_exec(host_exec),
        .chk_start_ff(chk_start_ff), .chk_len_kb_ff(chk_len_kb_ff),
        .boot_jump_ff(boot_jump_ff), .host_cmd_mode(host_cmd_mode));
    bdec_boot_agent u_agent (.clk(clk), .rst(rst), .go(go), .ok_s(ok_s), .ok_f(ok_f),
        .chk_start_ff(chk_start_ff), .chk_len_kb_ff(chk_len_kb_ff), .init_done(init_done),
        .chk_done(chk_done), .chk_ok(chk_ok));
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // ==========================================
    // helpers
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
            num_errors++;
        if (g !== e)
            $display("BAD t=%0t got %h exp %h", $time, g, e);
    endtask
    function automatic logic [16:0] exp_sel(input logic [31:0] a, input logic n);
        exp_sel = 0;
        if (n ? a < 32'h8000 : a >= 32'h10000 && a < 32'h18000)
            exp_sel[16] = 1;
        else if (n ? a >= 32'h10000 && a < 32'h11000 : a < 32'h10000)
            exp_sel[15] = 1;
        else if (a >= 32'h18800 && a < 32'h19000)
            exp_sel[14] = 1;
        else if (a >= 32'h19000 && a < 32'h1a000)
            exp_sel[13] = 1;
        else if (a[31:20] == 0 && a[15:8] == 0 && a[19:16] >= 2 && a[19:16] <= 14)
            exp_sel[a[19:16] - 2] = 1;
    endfunction
    // offset into the selected memory, rom folded to its 4K depth
    function automatic logic [23:0] exp_off(input logic [31:0] a, input logic n);
        logic [16:0] s;
        s = exp_sel(a, n);
        exp_off = s[16] ? {9'h000, a[14:0]} :
                  s[15] || s[13] ? {12'h000, a[11:0]} :
                  s[14] ? {13'h0000, a[10:0]} : 24'h00_0000;
    endfunction
    task sel(input logic [31:0] a, input logic n);
        @(posedge clk);
        #1 bus_req = 1;
        bus_wr = 0;
        bus_addr = a;
        #2 check({pfl_sel, rom_sel, dfl_sel, ram_sel, per_sel}, exp_sel(a, n));
        check(mem_offset, exp_off(a, n));
    endtask
    task cfg(input logic w, p, input logic [5:0] x, input logic [31:0] d);
        @(posedge clk);
        #1 {bus_req, bus_wr, bus_priv, bus_wdata} = {1'b1, w, p, d};
        bus_addr = {24'hffff_fe, x, 2'b00};
        #1 check(bus_wait, 1);
        @(posedge clk);
        #1 check(bus_wait, 0);
        rd = bus_rdata_ff;
        @(posedge clk);
        #1 bus_req = 0;
    endtask
    task rnd_map(input logic n);
        for (i = 0; i < 40; i++)
            sel(i < 12 ? corner[i] : $random(seed) & (i[0] ? 32'hfffff : 32'h1ffff), n);
    endtask
    task boot(input logic s, f);
        int k, starts, hm;
        {ok_s, ok_f, rst, starts, hm} = {s, f, 1'b1, 64'h0};
        repeat (2) @(posedge clk);
        #1 rst = 0;
        sel(0, 0);
        @(posedge clk);
        #1 go = 1;
        @(posedge clk);
        #1 go = 0;
        // host answers a command-mode device at once, one pulse only
        for (k = 0; k < 99 && boot_jump_ff !== 1'b1; k++)
        begin
            @(posedge clk);
            #1 host_exec = host_cmd_mode === 1'b1 && !host_exec;
            hm += host_cmd_mode === 1'b1;
            starts += chk_start_ff === 1'b1;
            if (chk_start_ff === 1'b1)
                check(chk_len_kb_ff, starts == 1 ? 2 : 32);
        end
        if (k == 99)
            check(boot_jump_ff, 1);
        if (k == 99)
            test_done;
        check(starts, s ? 1 : 2);
        check(hm != 0, !s && !f);
        sel(0, 1);
        sel(32'h0001_9ffc, 1);
        $display("test boot %0d%0d done", s, f);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {seed, num_errors, n_tests} = {32'hf0e8, 64'h0};
        {ce, bus_req, bus_wr, bus_priv, go, ok_s, ok_f, host_exec, rst} = 9'h101;
        {bus_addr, bus_wdata} = 0;
        repeat (6) @(posedge clk);
        #1 rst = 0;
        rnd_map(0);
        $display("test reset map done");
        cfg(0, 1, 6'h00, 0);
        check(rd, 0);
        cfg(0, 1, 6'h01, 0);
        check(rd, 32'h0001_0000);
        cfg(0, 1, 6'h3f, 0);
        check(rd, 0);
        cfg(1, 0, 6'h00, 1);
        cfg(0, 1, 6'h00, 0);
        check(rd, 0);
        sel(0, 0);
        cfg(1, 1, 6'h00, 1);
        cfg(0, 1, 6'h00, 0);
        check(rd, 1);
        rnd_map(1);
        // frozen decoder keeps the wait state; the ram base write lands once running
        @(posedge clk);
        #1 ce = 0;
        {bus_req, bus_wr, bus_priv, bus_wdata} = {1'b1, 1'b1, 1'b1, 32'h0010_0123};
        bus_addr = 32'hffff_fe1c;
        repeat (3) @(posedge clk);
        #1 check(bus_wait, 1);
        ce = 1;
        @(posedge clk);
        #1 check(bus_wait, 0);
        @(posedge clk);
        #1 bus_req = 0;
        cfg(1, 1, 6'h08, 32'h0000_0003);
        cfg(0, 1, 6'h07, 0);
        check(rd, 32'h0010_0000);
        @(posedge clk);
        #1 bus_req = 1;
        bus_addr = 32'h0010_1ffc;
        #2 check({pfl_sel, rom_sel, dfl_sel, ram_sel, per_sel}, 32'h0000_2000);
        check(mem_offset, 32'h0000_1ffc);
        $display("test config done");
        boot(1, 0);
        boot(0, 1);
        boot(0, 0);
        test_done;
    end
endmodule // tb_top
`default_nettype wire
